// ---- design/gauge_cmd_pkg.sv ----
// constants, field positions and types for the gauge command interpreter
// assumes a 16-bit serial word, three address bits on top
package gauge_cmd_pkg;
	localparam int WORD_BITS     = 16;
	localparam int FIELD_BITS    = 13;
	localparam int CNT_BITS      = 5;
	// address codes in word bits 15:13
	localparam logic [2:0] ADDR_CONFIG   = 3'h0; // power_enable_config_cmd
	localparam logic [2:0] ADDR_VELOCITY = 3'h1; // max_velocity_cmd
	// configuration field positions
	localparam int POS_DRIVE_EN  = 0;
	localparam int POS_RSV_LOW   = 1;
	localparam int POS_SLOWDOWN  = 2;
	localparam int POS_CAL_EN    = 3;
	localparam int POS_CAL_TGT   = 4;
	localparam int POS_EMU_DIS   = 5;
	localparam int POS_PHASE     = 6;
	localparam int POS_ZERO_SIDE = 7;
	localparam int POS_RSV_MID   = 8;
	localparam int POS_POS_SPD   = 9;
	localparam int POS_ACC_PTR   = 10;
	localparam int POS_READOUT   = 11;
	localparam int POS_NULL      = 12;
	// velocity field positions
	localparam int POS_VEL_CHG   = 8;
	localparam int VEL_IDX_BITS  = 8;
	// velocity table limits
	localparam logic [7:0] VEL_IDX_MIN = 8'h01;
	localparam logic [7:0] VEL_IDX_MAX = 8'he1; // 225
	// reset values
	localparam logic [12:0] CONFIG_RST   = 13'h0000;
	localparam logic [7:0]  VEL_LIMIT_RST = 8'he1;
	// calibration: 8.0 us reference at 1.0 MHz target
	localparam int CLK_MHZ        = 20;
	localparam int CAL_REF_NS     = 8000;
	localparam int CAL_REF_CYC    = CAL_REF_NS * CLK_MHZ / 1000;
	localparam int CAL_CNT_BITS   = 9;
	localparam logic [8:0] CAL_CNT_MAX = 9'h1ff;
	localparam logic [8:0] CAL_REF_CNT = 9'(CAL_REF_CYC);
	// readout selections
	typedef enum logic [1:0] {
		rd_status,
		rd_accum,
		rd_position,
		rd_speed
	} readout_t;
endpackage

// ---- design/gauge_word_if.sv ----
// carries one received serial word from the shifter to the decoder
// assumes both ends run on mclk
`timescale 1ns/1ps
`default_nettype none
interface gauge_word_if;
	logic        valid;
	logic [15:0] word;
	modport source (output valid, output word);
	modport sink   (input valid, input word);
endinterface
`default_nettype wire

// ---- design/gauge_serial_rx.sv ----
// serial input shifter: samples synchronised sclk, shifts si on falling edge
// assumes cs_n, sclk, si already pass two flip-flops in the parent
`timescale 1ns/1ps
`default_nettype none
module gauge_serial_rx
	import gauge_cmd_pkg::*;
(
	input  wire logic  mclk,
	input  wire logic  srst,
	input  wire logic  ce,
	input  wire logic  cs_n_s,
	input  wire logic  sclk_s,
	input  wire logic  si_s,
	gauge_word_if.source out
);
	logic [15:0] shift_r;
	logic [CNT_BITS-1:0] cnt_r;
	logic        sclk_d_r;
	logic        cs_d_r;
	logic        valid_r;
	logic [15:0] word_r;

	// edge history of synchronised lines
	always_ff @(posedge mclk) begin
		if (srst) begin
			sclk_d_r <= 1'b0;
			cs_d_r   <= 1'b1;
		end else if (ce) begin
			sclk_d_r <= sclk_s;
			cs_d_r   <= cs_n_s;
		end
	end

	// shift on sclk fall while selected; count runs 1 to 16, then wraps back to 1
	always_ff @(posedge mclk) begin
		if (srst) begin
			shift_r <= 16'h0000;
			cnt_r   <= '0;
		end else if (ce) begin
			if (cs_n_s && !cs_d_r) begin
				cnt_r <= '0;
			end else if (!cs_n_s && sclk_d_r && !sclk_s) begin
				shift_r <= {shift_r[14:0], si_s};
				cnt_r   <= (cnt_r == CNT_BITS'(15)) ? CNT_BITS'(16) : CNT_BITS'(cnt_r[3:0] + 4'h1);
			end
		end
	end

	// word is handed over only at cs rise after a whole multiple of 16
	always_ff @(posedge mclk) begin
		if (srst) begin
			valid_r <= 1'b0;
			word_r  <= 16'h0000;
		end else if (ce) begin
			valid_r <= cs_n_s && !cs_d_r && cnt_r == CNT_BITS'(16);
			if (cs_n_s && !cs_d_r)
				word_r <= shift_r;
		end
	end

	assign out.valid = valid_r;
	assign out.word  = word_r;
endmodule
`default_nettype wire

// ---- design/gauge_cal_timer.sv ----
// measures the cs reference pulse after a calibration command
// assumes cs_n_s is synchronised; trim value is oscillator code
`timescale 1ns/1ps
`default_nettype none
module gauge_cal_timer
	import gauge_cmd_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic       arm,
	input  wire logic       cs_n_s,
	input  wire logic       slowdown,
	output logic            busy,
	output logic            done,
	output logic            fault,
	output logic [8:0]      count
);
	typedef enum logic [1:0] {c_idle, c_wait, c_meas} cal_state_t;
	cal_state_t  state_r;
	logic [8:0]  cnt_r;
	logic        cs_d_r;
	logic        done_r;
	logic        fault_r;
	logic [8:0]  lim;

	// slowed oscillator tolerates a longer pulse before overrun
	assign lim = slowdown ? CAL_CNT_MAX : 9'(CAL_CNT_MAX - 9'h0aa);

	// pulse measurement sequence
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_r <= c_idle;
			cnt_r   <= 9'h000;
			cs_d_r  <= 1'b1;
			done_r  <= 1'b0;
			fault_r <= 1'b0;
		end else if (ce) begin
			cs_d_r <= cs_n_s;
			done_r <= 1'b0;
			case (state_r)
			c_idle: begin
				if (arm) begin
					state_r <= c_wait;
					fault_r <= 1'b0;
				end
			end
			c_wait: begin
				if (!cs_n_s && cs_d_r) begin
					state_r <= c_meas;
					cnt_r   <= 9'h000;
				end
			end
			c_meas: begin
				if (cs_n_s) begin
					state_r <= c_idle;
					done_r  <= 1'b1;
				end else if (cnt_r == lim) begin
					state_r <= c_idle;
					fault_r <= 1'b1;
				end else begin
					cnt_r <= 9'(cnt_r + 9'h001);
				end
			end
			default: state_r <= c_idle;
			endcase
		end
	end

	assign busy  = state_r != c_idle;
	assign done  = done_r;
	assign fault = fault_r;
	assign count = cnt_r;
endmodule
`default_nettype wire

// ---- design/gauge_config_velocity_cmd.sv ----
// configuration and velocity command decoder for one gauge driver
// assumes serial pins arrive asynchronously; motion engine sits outside
`timescale 1ns/1ps
`default_nettype none
module gauge_config_velocity_cmd
	import gauge_cmd_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire logic                  cs_n,
	input  wire logic                  sclk,
	input  wire logic                  si,
	input  wire logic                  pointer_moving_flag,
	input  wire logic [7:0]            current_velocity_step,
	output logic                       gauge_drive_enable,
	output logic                       standby,
	output logic                       osc_run,
	output logic                       osc_slowdown,
	output logic                       cal_target_select,
	output logic                       cal_active,
	output logic                       cal_fault,
	output logic [8:0]                 cal_trim,
	output logic                       emulation_disable,
	output logic                       motor_phase_type,
	output logic                       zero_side_select,
	output gauge_cmd_pkg::readout_t    readout_mode,
	output logic [7:0]                 velocity_limit,
	output logic                       decel_request
);
	import gauge_cmd_pkg::*;

	logic [1:0]  cs_sync_r;
	logic [1:0]  sclk_sync_r;
	logic [1:0]  si_sync_r;
	logic        cs_n_s;
	logic [12:0] config_r;
	logic [7:0]  vel_limit_r;
	logic        cal_arm_r;
	logic        cal_busy;
	logic        cal_done;
	logic        cal_fault_w;
	logic [8:0]  cal_cnt;
	logic [8:0]  trim_r;
	logic [12:0] field;
	logic [2:0]  addr;
	gauge_word_if rx_word ();

	// clamp an index to the velocity table range
	function automatic logic [7:0] clamp_index(input logic [7:0] idx);
		logic [7:0] r;
		r = idx;
		if (idx > VEL_IDX_MAX)
			r = VEL_IDX_MAX;
		else if (idx < VEL_IDX_MIN)
			r = VEL_IDX_MIN;
		return r;
	endfunction

	// two flip-flop synchronisers for the serial pins
	always_ff @(posedge mclk) begin
		if (srst) begin
			cs_sync_r   <= 2'h3;
			sclk_sync_r <= 2'h0;
			si_sync_r   <= 2'h0;
		end else if (ce) begin
			cs_sync_r   <= {cs_sync_r[0], cs_n};
			sclk_sync_r <= {sclk_sync_r[0], sclk};
			si_sync_r   <= {si_sync_r[0], si};
		end
	end
	assign cs_n_s = cs_sync_r[1];

	gauge_serial_rx u_rx (
		.mclk   (mclk),
		.srst   (srst),
		.ce     (ce),
		.cs_n_s (cs_n_s),
		.sclk_s (sclk_sync_r[1]),
		.si_s   (si_sync_r[1]),
		.out    (rx_word)
	);

	assign addr  = rx_word.word[15:13];
	assign field = rx_word.word[12:0];

	// configuration register; null command leaves it untouched
	always_ff @(posedge mclk) begin
		if (srst) begin
			config_r <= CONFIG_RST;
		end else if (ce) begin
			if (rx_word.valid && addr == ADDR_CONFIG && !field[POS_NULL]) begin
				config_r <= field;
				config_r[POS_CAL_EN] <= 1'b0; // calibration bit acts once
			end
		end
	end

	// calibration arming, only with gauge off or pointer still
	always_ff @(posedge mclk) begin
		if (srst) begin
			cal_arm_r <= 1'b0;
		end else if (ce) begin
			cal_arm_r <= rx_word.valid && addr == ADDR_CONFIG && !field[POS_NULL]
				&& field[POS_CAL_EN] && !cal_busy
				&& (!field[POS_DRIVE_EN] || !pointer_moving_flag);
		end
	end

	gauge_cal_timer u_cal (
		.mclk     (mclk),
		.srst     (srst),
		.ce       (ce),
		.arm      (cal_arm_r),
		.cs_n_s   (cs_n_s),
		.slowdown (config_r[POS_SLOWDOWN]),
		.busy     (cal_busy),
		.done     (cal_done),
		.fault    (cal_fault_w),
		.count    (cal_cnt)
	);

	// trim: target zero biases one step slow so frequency stays below target
	always_ff @(posedge mclk) begin
		if (srst) begin
			trim_r <= CAL_REF_CNT;
		end else if (ce && cal_done) begin
			trim_r <= config_r[POS_CAL_TGT] ? cal_cnt : 9'(cal_cnt + 9'h001);
		end
	end

	// velocity limit, applied only with change enable set
	always_ff @(posedge mclk) begin
		if (srst) begin
			vel_limit_r <= VEL_LIMIT_RST;
		end else if (ce) begin
			if (rx_word.valid && addr == ADDR_VELOCITY && field[POS_VEL_CHG])
				vel_limit_r <= clamp_index(field[7:0]);
		end
	end

	// readout choice; sub-selects ignored while status chosen
	always_comb begin
		if (!config_r[POS_READOUT])
			readout_mode = rd_status;
		else if (!config_r[POS_ACC_PTR])
			readout_mode = rd_accum;
		else if (!config_r[POS_POS_SPD])
			readout_mode = rd_position;
		else
			readout_mode = rd_speed;
	end

	assign gauge_drive_enable = config_r[POS_DRIVE_EN];
	assign standby            = !config_r[POS_DRIVE_EN];
	assign osc_run            = 1'b1;
	assign osc_slowdown       = config_r[POS_SLOWDOWN];
	assign cal_target_select  = config_r[POS_CAL_TGT];
	assign cal_active         = cal_busy;
	assign cal_fault          = cal_fault_w;
	assign cal_trim           = trim_r;
	assign emulation_disable  = config_r[POS_EMU_DIS];
	assign motor_phase_type   = config_r[POS_PHASE];
	assign zero_side_select   = config_r[POS_ZERO_SIDE];
	assign velocity_limit     = vel_limit_r;
	assign decel_request      = current_velocity_step > vel_limit_r;
endmodule
`default_nettype wire

// ---- verif/gauge_cmd_sva.sv ----
// port checker for the gauge command decoder
// assumes a bind to gauge_config_velocity_cmd, mclk domain only
`timescale 1ns/1ps
`default_nettype none
module gauge_cmd_sva (
	input wire logic       mclk,
	input wire logic       srst,
	input wire logic       cs_n,
	input wire logic       pointer_moving_flag,
	input wire logic [7:0] current_velocity_step,
	input wire logic       gauge_drive_enable,
	input wire logic       standby,
	input wire logic       osc_run,
	input wire logic       emulation_disable,
	input wire logic       cal_active,
	input wire logic       cal_fault,
	input wire logic [7:0] velocity_limit,
	input wire logic       decel_request
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	// reset must win even while srst is high, so no disable here
	rst_vals_a: assert property (disable iff (1'b0) srst |=>
		!gauge_drive_enable && !emulation_disable && velocity_limit == 8'he1)
		else $error("reset values wrong");
	stby_inv_a: assert property (standby == !gauge_drive_enable)
		else $error("standby not inverse of enable");
	osc_on_a: assert property (osc_run)
		else $error("oscillator stopped");
	// a word lands only after cs has been high a few cycles
	land_cs_a: assert property ($changed({velocity_limit, gauge_drive_enable,
		emulation_disable}) |-> cs_n && $past(cs_n, 3))
		else $error("register changed inside a frame");
	cal_gate_a: assert property ($rose(cal_active) |->
		!($past(gauge_drive_enable) && $past(pointer_moving_flag)))
		else $error("calibration accepted while moving");
	fault_src_a: assert property ($rose(cal_fault) |-> $past(cal_active))
		else $error("fault without calibration");
	lim_range_a: assert property (velocity_limit inside {[8'h01:8'he1]})
		else $error("limit out of table");
	decel_cmp_a: assert property (decel_request ==
		(current_velocity_step > velocity_limit)) else $error("decel request wrong");
endmodule
bind gauge_config_velocity_cmd gauge_cmd_sva chk (.mclk, .srst, .cs_n,
	.pointer_moving_flag, .current_velocity_step, .gauge_drive_enable, .standby,
	.osc_run, .emulation_disable, .cal_active, .cal_fault, .velocity_limit,
	.decel_request);
`default_nettype wire

// ---- verif/gauge_spi_master.sv ----
// serial master model: frames words on cs_n, sclk and si
// assumes decoder samples si on sclk fall, MSB first
`timescale 1ns/1ps
`default_nettype none
module gauge_spi_master (
	output logic cs_n,
	output logic sclk,
	output logic si
);
	// idle: cs high, sclk parked low, si at its pull-down level
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		si = 1'b0;
	end
	// 400 ns link clock, si moved mid-low so it never races the fall
	task automatic send(input logic [15:0] w, input int n);
		cs_n = 1'b0;
		#137;
		for (int i = 15; i >= 16 - n; i--) begin
			#100 si = w[i];
			#100 sclk = 1'b1;
			#200 sclk = 1'b0;
		end
		#100 si = 1'b0;
		cs_n = 1'b1;
		#400;
	endtask
	// reference pulse on cs alone, other lines stay still
	task automatic cs_pulse(input int ns);
		cs_n = 1'b0;
		#(ns) cs_n = 1'b1;
		#400;
	endtask
endmodule
`default_nettype wire

// ---- verif/tb_gauge_config_velocity_cmd.sv ----
// self-checking bench for the gauge command decoder
// assumes the serial master model drives the three serial pins
`timescale 1ns/1ps
`default_nettype none
module tb_gauge_config_velocity_cmd;
	import gauge_cmd_pkg::*;
	logic       mclk = 1'b0;
	logic       srst = 1'b1;
	logic       mov = 1'b0;
	logic [7:0] stp = 8'h00;
	logic       cs_n, sclk, si, en, stby, osc, slow, tgt, cal, flt, emu, ph, zs, dec;
	logic [8:0] trim;
	logic [8:0] trim0;
	logic       ce = 1'b1;
	logic [7:0] lim;
	readout_t   rd;
	int         n_fail = 0;
	int         num_checks = 0;
	wire logic [8:0] cfg = {en, stby, slow, tgt, emu, ph, zs, rd};
	always #25 mclk = ~mclk;
	gauge_spi_master bus (.cs_n(cs_n), .sclk(sclk), .si(si));
	gauge_config_velocity_cmd dut (.mclk(mclk), .srst(srst), .ce(ce), .cs_n(cs_n),
		.sclk(sclk), .si(si), .pointer_moving_flag(mov), .current_velocity_step(stp),
		.gauge_drive_enable(en), .standby(stby), .osc_run(osc), .osc_slowdown(slow),
		.cal_target_select(tgt), .cal_active(cal), .cal_fault(flt), .cal_trim(trim),
		.emulation_disable(emu), .motor_phase_type(ph), .zero_side_select(zs),
		.readout_mode(rd), .velocity_limit(lim), .decel_request(dec));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// settle a few cycles past the cs rise before looking
	task automatic wr(input logic [2:0] a, input logic [12:0] f, input int n);
		bus.send({a, f}, n);
		repeat (10) @(negedge mclk);
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// watchdog: run needs about 235 us
	initial begin
		#1000000;
		n_fail++;
		end_of_test();
	end
	initial begin
		repeat (3) @(negedge mclk);
		srst = 1'b0;
		chk(16'(cfg), 16'h0080);
		chk(16'(lim), 16'h00e1);
		wr(3'h0, 13'h0ef5, 16);
		chk(16'(cfg), 16'h017f);
		wr(3'h0, 13'h1000, 16);
		chk(16'(cfg), 16'h017f);
		wr(3'h2, 13'h0000, 16);
		chk(16'(cfg), 16'h017f);
		wr(3'h0, 13'h0000, 15);
		chk(16'(cfg), 16'h017f);
		// every readout code, sub-selects ignored when status chosen
		for (int k = 0; k < 8; k++) begin
			wr(3'h0, {1'b0, 3'(k), 9'h001}, 16);
			chk(16'(rd), !k[2] ? 16'h0 : !k[1] ? 16'h1 : k[0] ? 16'h3 : 16'h2);
		end
		wr(3'h0, 13'h0000, 16);
		chk(16'(cfg), 16'h0080);
		// clock enable low freezes everything, so a whole frame is lost
		ce = 1'b0;
		wr(3'h0, 13'h0001, 16);
		chk(16'(cfg), 16'h0080);
		ce = 1'b1;
		wr(3'h1, 13'h0140, 16);
		chk(16'(lim), 16'h0040);
		wr(3'h1, 13'h0077, 16);
		chk(16'(lim), 16'h0040);
		stp = 8'h41;
		@(negedge mclk);
		chk(16'(dec), 16'h1);
		stp = 8'h40;
		@(negedge mclk);
		chk(16'(dec), 16'h0);
		wr(3'h1, 13'h01ff, 16);
		chk(16'(lim), 16'h00e1);
		// 8 us reference is 160 cycles, one added for the low target
		wr(3'h0, 13'h0008, 16);
		chk(16'(cal), 16'h1);
		bus.cs_pulse(8000);
		repeat (10) @(negedge mclk);
		chk(16'(trim > 9'h09f && trim < 9'h0a3 && !cal && !flt), 16'h1);
		// centred target drops the one-step slow bias of the low target
		trim0 = trim;
		wr(3'h0, 13'h0018, 16);
		bus.cs_pulse(8000);
		repeat (10) @(negedge mclk);
		chk(16'(trim + 9'h001), 16'(trim0));
		chk(16'(tgt), 16'h1);
		wr(3'h0, 13'h0008, 16);
		bus.cs_pulse(20000);
		repeat (10) @(negedge mclk);
		chk(16'(flt), 16'h1);
		wr(3'h0, 13'h000c, 16);
		bus.cs_pulse(20000);
		repeat (10) @(negedge mclk);
		chk(16'(flt), 16'h0);
		wr(3'h0, 13'h0001, 16);
		mov = 1'b1;
		wr(3'h0, 13'h0009, 16);
		chk(16'(cal), 16'h0);
		end_of_test();
	end
endmodule
`default_nettype wire
